// >>> verilog/bwl_defs.svh
// Purpose: Shared constants for the wrap and latency configuration link
// Assumes: 100 MHz system clock, serial link in single-wire form
// Notes: Included by the package and the testbench
`ifndef BWL_DEFS_SVH
`define BWL_DEFS_SVH

// ==========================================================
// Opcodes
`define BWL_OP_RD_CFG3 8'h33
`define BWL_OP_RD_ANY 8'h65
`define BWL_OP_WR_REGS 8'h01
`define BWL_OP_WR_ANY 8'h71
`define BWL_OP_SET_BURST 8'h77
`define BWL_OP_NV_WEN 8'h06

// ==========================================================
// Register addresses on the any-register commands
`define BWL_ADDR_BOOT 24'h000005
`define BWL_ADDR_WORK 24'h800005

// ==========================================================
// Configuration fields and values
`define BWL_CFG_DEFAULT 8'h78
`define BWL_CFG_MASK 8'h7f
`define BWL_WL_HI 6
`define BWL_WL_LO 5
`define BWL_WE_BIT 4
`define BWL_RL_HI 3
`define BWL_RL_LO 0
`define BWL_LAT_ZERO_DUMMY 4'h8
`define BWL_FIXED_DUMMY 4'h1
`define BWL_MODE_NONE 3'h0
`define BWL_MODE_DUAL_IO 3'h4
`define BWL_MODE_QUAD_IO 3'h2
`define BWL_MODE_DDR 3'h1

// ==========================================================
// Bit counts within a frame
`define BWL_CNT_OPCODE 6'h08
`define BWL_CNT_BURST 6'h10
`define BWL_CNT_ADDR 6'h20
`define BWL_CNT_DATA 6'h28
`define BWL_CNT_MAX 6'h3f

// ==========================================================
// Controller registers and command fields
`define BWL_REG_CMD 5'h00
`define BWL_REG_ADDR 5'h04
`define BWL_REG_TXD 5'h08
`define BWL_REG_RXD 5'h0c
`define BWL_REG_STAT 5'h10
`define BWL_CMD_NB_HI 10
`define BWL_CMD_NB_LO 8
`define BWL_CMD_DUM_HI 15
`define BWL_CMD_DUM_LO 12
`define BWL_CMD_HAS_ADDR 16
`define BWL_CMD_IS_READ 17
`define BWL_HDR_SHORT 7'h08
`define BWL_HDR_LONG 7'h20

// ==========================================================
// Link clock timing
`define BWL_SYS_NS 10
`define BWL_SCK_HALF_NS 40
`define BWL_SCK_HALF_CYC ((`BWL_SCK_HALF_NS + `BWL_SYS_NS - 1) / `BWL_SYS_NS)

`endif

// >>> verilog/bwl_pkg.sv
// Purpose: Types for the wrap and latency configuration ends
// Assumes: bwl_defs.svh on the include path
// Notes: Latency lookup lives here; only the device uses it, the host takes its dummy count from software
`default_nettype none
`include "bwl_defs.svh"

package bwl_pkg;

	typedef enum logic [3:0] {
		BWL_CLS_FIXED_ONE = 4'h0,
		BWL_CLS_FAST = 4'h1,
		BWL_CLS_DUAL_OUT = 4'h2,
		BWL_CLS_QUAD_OUT = 4'h3,
		BWL_CLS_DUAL_IO = 4'h4,
		BWL_CLS_QUAD_IO = 4'h5,
		BWL_CLS_DDR_QUAD_IO = 4'h6,
		BWL_CLS_SECURITY = 4'h7,
		BWL_CLS_ANY_REG = 4'h8,
		BWL_CLS_PARAMS = 4'h9
	} bwl_read_class_t;

	typedef enum logic [1:0] {
		BWL_H_IDLE = 2'b00,
		BWL_H_SHIFT = 2'b01,
		BWL_H_TAIL = 2'b11,
		BWL_H_GAP = 2'b10
	} bwl_host_st_t;

	typedef struct packed {
		logic sck_s1, sck_s2, sck_q;
		logic cs_s1, cs_s2, cs_q;
		logic si_s1, si_s2;
		logic [5:0] cnt;
		logic [7:0] op;
		logic [31:0] in_sr;
		logic [23:0] addr;
		logic [7:0] pend;
		logic pend_nv, pend_v;
		logic wel;
		logic [7:0] boot;
		logic [7:0] work;
		logic [7:0] out_sr;
		logic so;
		logic [3:0] dummy;
		logic [2:0] mode;
		logic wrap_act;
	} bwl_dev_t;

	typedef struct packed {
		bwl_host_st_t st;
		logic [2:0] div;
		logic sck, cs_n, si;
		logic so_s1, so_s2;
		logic [17:0] cmd;
		logic [23:0] addr;
		logic [31:0] txd;
		logic [31:0] rx;
		logic [63:0] sr;
		logic [6:0] k, total, hdr, dend;
		logic [31:0] rdata;
	} bwl_host_t;

	// Dummy cycles a read class needs for a given latency code
	function automatic logic [3:0] bwl_dummy_for(bwl_read_class_t cls, logic [3:0] code);
		logic [3:0] d;
		d = (code == 4'h0) ? `BWL_LAT_ZERO_DUMMY : code;
		if (cls == BWL_CLS_FIXED_ONE) begin
			d = `BWL_FIXED_DUMMY;
		end
		return d;
	endfunction

	// Mode-bit cycles are separate from the latency count
	function automatic logic [2:0] bwl_mode_for(bwl_read_class_t cls);
		logic [2:0] m;
		m = `BWL_MODE_NONE;
		case (cls)
			BWL_CLS_DUAL_IO: m = `BWL_MODE_DUAL_IO;
			BWL_CLS_QUAD_IO: m = `BWL_MODE_QUAD_IO;
			BWL_CLS_DDR_QUAD_IO: m = `BWL_MODE_DDR;
			default: m = `BWL_MODE_NONE;
		endcase
		return m;
	endfunction

endpackage : bwl_pkg

`default_nettype wire

// >>> verilog/bwl_link_if.sv
// Purpose: Serial link between configuration controller and device
// Assumes: Mode 0 framing, select active low
// Notes: Single-wire data each way
`default_nettype none

interface bwl_link_if;
	logic sck;
	logic cs_n;
	logic si;
	logic so;

	modport host (output sck, output cs_n, output si, input so);
	modport device (input sck, input cs_n, input si, output so);
endinterface : bwl_link_if

`default_nettype wire

// >>> verilog/bwl_cfg_device.sv
// Purpose: Wrap and latency configuration registers of the flash device
// Assumes: Link sampled by CLK_SYS; link clock well below a quarter of it
// Notes: Boot copy reloads the working copy on a hardware or software reset
`default_nettype none

module bwl_cfg_device
	import bwl_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Reset requests that reload the working copy
	input wire logic HW_RESET,
	input wire logic SW_RESET,
	// Read path query
	input wire bwl_read_class_t READ_CLASS,
	output logic [3:0] DUMMY_CYCLES,
	output logic [2:0] MODE_CYCLES,
	output logic WRAP_ACTIVE,
	output logic [1:0] WRAP_LENGTH,
	// Register views
	output logic [7:0] WORKING_CONFIG,
	output logic [7:0] BOOT_CONFIG,
	// Serial link
	bwl_link_if.device LINK
);

	// ==========================================================
	// State
	bwl_dev_t r;
	bwl_dev_t next_r;

	logic rise;
	logic fall;
	logic cs_fall;
	logic cs_rise;
	logic [31:0] shifted;
	logic [5:0] cnt_inc;
	logic [3:0] any_dummy;
	logic [5:0] data_start;
	logic [5:0] since_start;
	logic reloading;

	// Value returned for an addressed register; unknown addresses read zero
	function automatic logic [7:0] reg_value(logic [23:0] a, logic [7:0] boot, logic [7:0] work);
		logic [7:0] v;
		v = 8'h00;
		if (a == `BWL_ADDR_BOOT) begin
			v = boot;
		end else if (a == `BWL_ADDR_WORK) begin
			v = work;
		end
		return v & `BWL_CFG_MASK;
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		next_r = r;
		// Two flops on every link input before any logic looks at it
		next_r.sck_s1 = LINK.sck;
		next_r.sck_s2 = r.sck_s1;
		next_r.sck_q = r.sck_s2;
		next_r.cs_s1 = LINK.cs_n;
		next_r.cs_s2 = r.cs_s1;
		next_r.cs_q = r.cs_s2;
		next_r.si_s1 = LINK.si;
		next_r.si_s2 = r.si_s1;

		rise = r.sck_s2 & ~r.sck_q & ~r.cs_s2;
		fall = ~r.sck_s2 & r.sck_q & ~r.cs_s2;
		cs_fall = ~r.cs_s2 & r.cs_q;
		cs_rise = r.cs_s2 & ~r.cs_q;
		shifted = {r.in_sr[30:0], r.si_s2};
		cnt_inc = (r.cnt == `BWL_CNT_MAX) ? r.cnt : 6'(r.cnt + 6'h01);
		any_dummy = bwl_dummy_for(BWL_CLS_ANY_REG, r.work[`BWL_RL_HI:`BWL_RL_LO]);
		data_start = 6'(`BWL_CNT_ADDR + {2'h0, any_dummy});
		since_start = 6'(cnt_inc - data_start);
		reloading = HW_RESET | SW_RESET;

		if (cs_fall) begin
			next_r.cnt = 6'h00;
			next_r.op = 8'h00;
			next_r.pend_nv = 1'b0;
			next_r.pend_v = 1'b0;
			next_r.out_sr = 8'h00;
		end

		if (rise) begin
			next_r.in_sr = shifted;
			next_r.cnt = cnt_inc;
			if (cnt_inc == `BWL_CNT_OPCODE) begin
				next_r.op = shifted[7:0];
				if (shifted[7:0] == `BWL_OP_NV_WEN) begin
					next_r.wel = 1'b1;
				end
				if (shifted[7:0] == `BWL_OP_RD_CFG3) begin
					next_r.out_sr = r.work & `BWL_CFG_MASK;
				end
			end else begin
				case (r.op)
					`BWL_OP_RD_CFG3: begin
						// Register byte repeats every eight clocks until the bit counter saturates at 63
						if (cnt_inc[2:0] == 3'h0) begin
							next_r.out_sr = r.work & `BWL_CFG_MASK;
						end
					end
					`BWL_OP_RD_ANY: begin
						if (cnt_inc == `BWL_CNT_ADDR) begin
							next_r.addr = shifted[23:0];
						end
						// First data bit leaves on the fall after the last dummy
						if (cnt_inc >= data_start && since_start[2:0] == 3'h0) begin
							next_r.out_sr = reg_value(r.addr, r.boot, r.work);
						end
					end
					`BWL_OP_WR_REGS: begin
						// Fourth data byte is this register; earlier ones belong elsewhere
						if (cnt_inc == `BWL_CNT_DATA) begin
							next_r.pend = shifted[7:0] & `BWL_CFG_MASK;
							next_r.pend_nv = 1'b1;
							next_r.pend_v = 1'b1;
						end
					end
					`BWL_OP_WR_ANY: begin
						if (cnt_inc == `BWL_CNT_ADDR) begin
							next_r.addr = shifted[23:0];
						end
						if (cnt_inc == `BWL_CNT_DATA) begin
							next_r.pend = shifted[7:0] & `BWL_CFG_MASK;
							next_r.pend_nv = (r.addr == `BWL_ADDR_BOOT);
							next_r.pend_v = (r.addr == `BWL_ADDR_WORK);
						end
					end
					`BWL_OP_SET_BURST: begin
						if (cnt_inc == `BWL_CNT_BURST) begin
							next_r.pend = shifted[7:0] & `BWL_CFG_MASK;
							next_r.pend_v = 1'b1;
						end
					end
					default: begin
						next_r.out_sr = r.out_sr;
					end
				endcase
			end
		end

		if (fall) begin
			next_r.so = r.out_sr[7];
			next_r.out_sr = {r.out_sr[6:0], 1'b0};
		end

		// Writes take effect only when the frame closes, so a cut frame changes neither configuration copy
		if (cs_rise) begin
			next_r.so = 1'b0;
			if (r.pend_nv && r.wel) begin
				next_r.boot = r.pend;
			end
			if (r.pend_v) begin
				next_r.work = r.pend;
			end
			if (r.op == `BWL_OP_WR_REGS || r.op == `BWL_OP_WR_ANY) begin
				next_r.wel = 1'b0;
			end
			next_r.pend_nv = 1'b0;
			next_r.pend_v = 1'b0;
		end

		// Hardware or software reset reloads the working copy and wins over a commit to it; a boot copy commit in the same cycle still lands
		if (reloading) begin
			next_r.work = r.boot;
			next_r.wel = 1'b0;
			next_r.pend_nv = 1'b0;
			next_r.pend_v = 1'b0;
		end

		// Read path settings follow the read class and the working copy, never the boot copy
		next_r.dummy = bwl_dummy_for(READ_CLASS, r.work[`BWL_RL_HI:`BWL_RL_LO]);
		next_r.mode = bwl_mode_for(READ_CLASS);
		next_r.wrap_act = ~r.work[`BWL_WE_BIT] &&
			(READ_CLASS == BWL_CLS_QUAD_IO || READ_CLASS == BWL_CLS_DDR_QUAD_IO);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			r <= '0;
			r.sck_s1 <= 1'b0;
			r.cs_s1 <= 1'b1;
			r.cs_s2 <= 1'b1;
			r.cs_q <= 1'b1;
			// Power-on reset: boot defaults, and the same defaults in the working copy
			r.boot <= `BWL_CFG_DEFAULT;
			r.work <= `BWL_CFG_DEFAULT;
			r.dummy <= `BWL_FIXED_DUMMY;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Outputs
	assign DUMMY_CYCLES = r.dummy;
	assign MODE_CYCLES = r.mode;
	assign WRAP_ACTIVE = r.wrap_act;
	assign WRAP_LENGTH = r.work[`BWL_WL_HI:`BWL_WL_LO];
	assign WORKING_CONFIG = r.work;
	assign BOOT_CONFIG = r.boot;
	assign LINK.so = r.so;

endmodule // bwl_cfg_device

`default_nettype wire

// >>> verilog/bwl_cfg_host.sv
// Purpose: Controller end that issues configuration commands on the link
// Assumes: Software sets opcode, address, dummy count and byte count
// Notes: Link clock made by a divider; data sampled at the falling edge
`default_nettype none

module bwl_cfg_host
	import bwl_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Register port
	input wire logic [4:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// Serial link
	bwl_link_if.host LINK
);

	// ==========================================================
	// State
	localparam logic [2:0] HALF_LAST = 3'(`BWL_SCK_HALF_CYC - 1);

	bwl_host_t r;
	bwl_host_t next_r;
	logic tick;
	logic [6:0] kn;
	logic [6:0] hdr;
	logic [6:0] dend;

	always_comb begin
		next_r = r;
		next_r.so_s1 = LINK.so;
		next_r.so_s2 = r.so_s1;
		next_r.rdata = 32'h0;
		tick = (r.div == HALF_LAST);
		next_r.div = (r.st == BWL_H_IDLE || tick) ? 3'h0 : 3'(r.div + 3'h1);
		kn = 7'(r.k + 7'h01);
		hdr = REG_WDATA[`BWL_CMD_HAS_ADDR] ? `BWL_HDR_LONG : `BWL_HDR_SHORT;
		dend = 7'(hdr + {3'h0, REG_WDATA[`BWL_CMD_DUM_HI:`BWL_CMD_DUM_LO]});

		// ==========================================================
		// Register port; reads answer one cycle later
		if (REG_RD) begin
			if (REG_ADDR == `BWL_REG_CMD) begin
				next_r.rdata = {14'h0, r.cmd};
			end else if (REG_ADDR == `BWL_REG_ADDR) begin
				next_r.rdata = {8'h0, r.addr};
			end else if (REG_ADDR == `BWL_REG_TXD) begin
				next_r.rdata = r.txd;
			end else if (REG_ADDR == `BWL_REG_RXD) begin
				next_r.rdata = r.rx;
			end else if (REG_ADDR == `BWL_REG_STAT) begin
				next_r.rdata = {31'h0, r.st != BWL_H_IDLE};
			end
		end
		if (REG_WR) begin
			if (REG_ADDR == `BWL_REG_ADDR) begin
				next_r.addr = REG_WDATA[23:0];
			end else if (REG_ADDR == `BWL_REG_TXD) begin
				next_r.txd = REG_WDATA;
			end else if (REG_ADDR == `BWL_REG_CMD && r.st == BWL_H_IDLE) begin
				// Dummy count is software's choice; it must match the device's latency code
				next_r.cmd = REG_WDATA[17:0];
				next_r.hdr = hdr;
				next_r.dend = dend;
				next_r.total = 7'(dend + {1'b0, REG_WDATA[`BWL_CMD_NB_HI:`BWL_CMD_NB_LO], 3'h0});
				next_r.sr = REG_WDATA[`BWL_CMD_HAS_ADDR] ? {REG_WDATA[7:0], r.addr, r.txd}
					: {REG_WDATA[7:0], r.txd, 24'h0};
				next_r.si = REG_WDATA[7];
				next_r.cs_n = 1'b0;
				next_r.sck = 1'b0;
				next_r.k = 7'h00;
				next_r.rx = 32'h0;
				next_r.st = BWL_H_SHIFT;
			end
		end

		// ==========================================================
		// Frame sequencer
		case (r.st)
			BWL_H_SHIFT: begin
				if (tick && !r.sck) begin
					next_r.sck = 1'b1;
				end else if (tick) begin
					next_r.sck = 1'b0;
					if (r.cmd[`BWL_CMD_IS_READ] && r.k >= r.dend) begin
						next_r.rx = {r.rx[30:0], r.so_s2};
					end
					if (r.k < r.hdr || r.k >= r.dend) begin
						next_r.sr = {r.sr[62:0], 1'b0};
					end
					next_r.k = kn;
					if (kn == r.total) begin
						next_r.si = 1'b0;
						next_r.st = BWL_H_TAIL;
					end else if (kn >= r.hdr && kn < r.dend) begin
						next_r.si = 1'b0;
					end else if (r.cmd[`BWL_CMD_IS_READ] && kn >= r.dend) begin
						next_r.si = 1'b0;
					end else if (r.k < r.hdr || r.k >= r.dend) begin
						next_r.si = r.sr[62];
					end else begin
						next_r.si = r.sr[63];
					end
				end
			end
			BWL_H_TAIL: begin
				if (tick) begin
					next_r.cs_n = 1'b1;
					next_r.st = BWL_H_GAP;
				end
			end
			BWL_H_GAP: begin
				if (tick) begin
					next_r.st = BWL_H_IDLE;
				end
			end
			// Idle keeps whatever a command write has just started
			default: begin
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			r <= '0;
			r.cs_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Outputs
	assign REG_RDATA = r.rdata;
	assign LINK.sck = r.sck;
	assign LINK.cs_n = r.cs_n;
	assign LINK.si = r.si;

endmodule // bwl_cfg_host

`default_nettype wire

// >>> sim/bwl_link_checker.sv
// Purpose: Concurrent checks on the configuration link and device outputs
// Assumes: One clock domain, CLK_SYS
// Notes: Instantiated beside the link interface, no bind
`default_nettype none

module bwl_link_checker
	import bwl_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic so,
	// Device side
	input wire logic HW_RESET,
	input wire logic SW_RESET,
	input wire bwl_read_class_t READ_CLASS,
	input wire logic [3:0] DUMMY_CYCLES,
	input wire logic [2:0] MODE_CYCLES,
	input wire logic WRAP_ACTIVE,
	input wire logic [1:0] WRAP_LENGTH,
	input wire logic [7:0] WORKING_CONFIG,
	input wire logic [7:0] BOOT_CONFIG
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	// ==========================================================
	// Read path outputs are only compared once their causes have held still
	sequence s_settled;
		($stable(WORKING_CONFIG) && $stable(READ_CLASS) && $past(RST_N)) [*2];
	endsequence

	a_bit7_zero: assert property (!WORKING_CONFIG[7] && !BOOT_CONFIG[7])
		else $error("reserved bit set");
	a_reset_reload: assert property ((HW_RESET || SW_RESET) |=> WORKING_CONFIG == $past(BOOT_CONFIG))
		else $error("working copy not reloaded");
	a_work_guard: assert property ($changed(WORKING_CONFIG) |-> cs_n || $past(HW_RESET || SW_RESET))
		else $error("working copy changed inside frame");
	a_boot_guard: assert property ($changed(BOOT_CONFIG) |-> cs_n && $past(cs_n))
		else $error("boot copy changed inside frame");
	a_wrap_len: assert property (s_settled |-> WRAP_LENGTH == WORKING_CONFIG[6:5])
		else $error("wrap length differs");
	a_dummy_map: assert property (s_settled |-> DUMMY_CYCLES == ((READ_CLASS == BWL_CLS_FIXED_ONE) ? 4'h1 :
		(WORKING_CONFIG[3:0] == 4'h0) ? 4'h8 : WORKING_CONFIG[3:0]))
		else $error("dummy count wrong");
	a_mode_map: assert property (s_settled |-> MODE_CYCLES == ((READ_CLASS == BWL_CLS_DUAL_IO) ? 3'h4 :
		(READ_CLASS == BWL_CLS_QUAD_IO) ? 3'h2 : (READ_CLASS == BWL_CLS_DDR_QUAD_IO) ? 3'h1 : 3'h0))
		else $error("mode count wrong");
	a_wrap_gate: assert property (s_settled |-> WRAP_ACTIVE == ((READ_CLASS == BWL_CLS_QUAD_IO ||
		READ_CLASS == BWL_CLS_DDR_QUAD_IO) && !WORKING_CONFIG[4]))
		else $error("wrap gate wrong");
	a_idle_clock: assert property (cs_n |-> !sck)
		else $error("link clock outside frame");
	a_half_period: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
		else $error("link clock high time wrong");

	c_reload: cover property (HW_RESET || SW_RESET);
	c_wrap: cover property (WRAP_ACTIVE);
	c_reply: cover property (!cs_n && $rose(so));
	c_send: cover property (!cs_n && $rose(si));
endmodule // bwl_link_checker

`default_nettype wire

// >>> sim/test_burst_wrap_read_latency_config.sv
// Purpose: Self-checking bench for both configuration link ends
// Assumes: Host and device joined by one link interface
// Notes: Read data checked through an expectation queue
`default_nettype none
`include "bwl_defs.svh"

module test_burst_wrap_read_latency_config import bwl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys = 1'b0, rst_n = 1'b0, hw_reset = 1'b0, sw_reset = 1'b0;
	bwl_read_class_t read_class = BWL_CLS_FAST;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, pend = 1'b0, pend_d = 1'b0;
	logic [3:0] dummy_cycles;
	logic [2:0] mode_cycles;
	logic wrap_active;
	logic [1:0] wrap_length;
	logic [7:0] working_config, boot_config, wire_sr, ew, eb, v;
	logic [7:0] cfgs [3] = '{8'h00, 8'h3f, 8'h41};
	int mismatches = 0, comparisons = 0, cycles = 0, wire_cnt = 0;
	logic [31:0] exp_q [$];
	bwl_link_if link();

	always #5 clk_sys = ~clk_sys;

	bwl_cfg_host bwl_cfg_host_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LINK(link.host));
	bwl_cfg_device bwl_cfg_device_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .HW_RESET(hw_reset), .SW_RESET(sw_reset),
		.READ_CLASS(read_class), .DUMMY_CYCLES(dummy_cycles), .MODE_CYCLES(mode_cycles),
		.WRAP_ACTIVE(wrap_active), .WRAP_LENGTH(wrap_length), .WORKING_CONFIG(working_config),
		.BOOT_CONFIG(boot_config), .LINK(link.device));
	bwl_link_checker bwl_link_checker_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .sck(link.sck), .cs_n(link.cs_n),
		.si(link.si), .so(link.so), .HW_RESET(hw_reset), .SW_RESET(sw_reset), .READ_CLASS(read_class),
		.DUMMY_CYCLES(dummy_cycles), .MODE_CYCLES(mode_cycles), .WRAP_ACTIVE(wrap_active),
		.WRAP_LENGTH(wrap_length), .WORKING_CONFIG(working_config), .BOOT_CONFIG(boot_config));

	// ==========================================================
	// Tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Strobes stay as set until the next call, so back-to-back calls never assign twice per step
	task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [31:0] d,
		input logic c = 1'b0);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		pend <= c;
		@(posedge clk_sys);
	endtask

	function automatic logic [3:0] dmy(input logic [7:0] c);
		return (c[3:0] == 4'h0) ? 4'h8 : c[3:0];
	endfunction

	task automatic frame(input logic [7:0] op, input logic [23:0] a, input logic [31:0] d,
		input logic [2:0] nb, input logic [3:0] dm, input logic ha, input logic rd);
		int n;
		logic b;
		n = 0;
		b = 1'b1;
		wire_cnt = 0;
		bus(1'b1, 1'b0, `BWL_REG_ADDR, {8'h00, a});
		bus(1'b1, 1'b0, `BWL_REG_TXD, d);
		bus(1'b1, 1'b0, `BWL_REG_CMD, {14'h0, rd, ha, dm, 1'b0, nb, op});
		// One-cycle read strobe; the answer is taken at the edge that ends its cycle
		while (b && n < 2000) begin
			bus(1'b0, 1'b1, `BWL_REG_STAT, 32'h0);
			bus(1'b0, 1'b0, 5'h00, 32'h0);
			b = reg_rdata[0];
			n++;
		end
		bus(1'b0, 1'b0, 5'h00, 32'h0);
		// Device commits a few cycles after select rises
		repeat (4) @(posedge clk_sys);
		check("busy", {31'h0, b}, 32'h0);
		check("opcode", {24'h0, wire_sr}, {24'h0, op});
	endtask

	task automatic rdx(input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, `BWL_REG_RXD, 32'h0, 1'b1);
		bus(1'b0, 1'b0, 5'h00, 32'h0);
	endtask

	// ==========================================================
	// Monitors
	always @(posedge link.sck) begin
		if (wire_cnt < 8) begin
			wire_sr = {wire_sr[6:0], link.si};
			wire_cnt++;
		end
	end

	always @(posedge clk_sys) begin
		if (pend_d) begin
			check("rxd", reg_rdata, exp_q.pop_front());
		end
		pend_d <= pend;
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			close_out();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		v = 8'($urandom(32'hfd08252f));
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		eb = 8'h78;
		ew = 8'h78;
		@(posedge clk_sys);
		check("boot", {24'h0, boot_config}, {24'h0, eb});
		check("work", {24'h0, working_config}, {24'h0, ew});
		frame(8'h33, 24'h0, 32'h0, 3'h4, 4'h0, 1'b0, 1'b1);
		rdx({4{ew}});
		$display("reset test done");

		v = 8'($urandom()) | 8'h80;
		frame(8'h77, 24'h0, {v, 24'h0}, 3'h1, 4'h0, 1'b0, 1'b0);
		ew = v & 8'h7f;
		check("work", {24'h0, working_config}, {24'h0, ew});
		check("boot", {24'h0, boot_config}, {24'h0, eb});
		check("wrap_len", {30'h0, wrap_length}, {30'h0, ew[6:5]});
		frame(8'h33, 24'h0, 32'h0, 3'h4, 4'h0, 1'b0, 1'b1);
		rdx({4{ew}});
		$display("burst length test done");

		v = 8'($urandom());
		frame(8'h71, `BWL_ADDR_BOOT, {v, 24'h0}, 3'h1, 4'h0, 1'b1, 1'b0);
		check("boot", {24'h0, boot_config}, {24'h0, eb});
		frame(8'h06, 24'h0, 32'h0, 3'h0, 4'h0, 1'b0, 1'b0);
		frame(8'h71, `BWL_ADDR_BOOT, {v, 24'h0}, 3'h1, 4'h0, 1'b1, 1'b0);
		eb = v & 8'h7f;
		check("boot", {24'h0, boot_config}, {24'h0, eb});
		check("work", {24'h0, working_config}, {24'h0, ew});
		// One byte only: the device's bit counter tops out before a long read ends
		frame(8'h65, `BWL_ADDR_BOOT, 32'h0, 3'h1, dmy(ew), 1'b1, 1'b1);
		rdx({24'h0, eb});
		$display("boot write test done");

		for (int i = 0; i < 2; i++) begin
			v = 8'($urandom());
			frame(8'h71, `BWL_ADDR_WORK, {v, 24'h0}, 3'h1, 4'h0, 1'b1, 1'b0);
			check("work", {24'h0, working_config}, {24'h0, v & 8'h7f});
			hw_reset <= (i == 0);
			sw_reset <= (i == 1);
			@(posedge clk_sys);
			hw_reset <= 1'b0;
			sw_reset <= 1'b0;
			repeat (2) @(posedge clk_sys);
			ew = eb;
			check("work", {24'h0, working_config}, {24'h0, ew});
		end
		$display("reset reload test done");

		v = 8'($urandom());
		frame(8'h06, 24'h0, 32'h0, 3'h0, 4'h0, 1'b0, 1'b0);
		frame(8'h01, 24'h0, {24'($urandom()), v}, 3'h4, 4'h0, 1'b0, 1'b0);
		eb = v & 8'h7f;
		ew = eb;
		check("boot", {24'h0, boot_config}, {24'h0, eb});
		check("work", {24'h0, working_config}, {24'h0, ew});
		$display("register write test done");

		foreach (cfgs[k]) begin
			frame(8'h77, 24'h0, {cfgs[k], 24'h0}, 3'h1, 4'h0, 1'b0, 1'b0);
			ew = cfgs[k];
			for (int c = 0; c < 10; c++) begin
				bwl_read_class_t cl;
				cl = bwl_read_class_t'(c);
				read_class <= cl;
				repeat (3) @(posedge clk_sys);
				check("dummy", {28'h0, dummy_cycles}, {28'h0, (cl == BWL_CLS_FIXED_ONE) ? 4'h1 : dmy(ew)});
				check("mode", {29'h0, mode_cycles}, (cl == BWL_CLS_DUAL_IO) ? 32'h4 : (cl == BWL_CLS_QUAD_IO) ? 32'h2 :
					(cl == BWL_CLS_DDR_QUAD_IO) ? 32'h1 : 32'h0);
				check("wrap", {31'h0, wrap_active}, {31'h0, (cl == BWL_CLS_QUAD_IO || cl == BWL_CLS_DDR_QUAD_IO) &&
					!ew[4]});
				check("wrap_len", {30'h0, wrap_length}, {30'h0, ew[6:5]});
			end
		end
		$display("read class test done");
		repeat (4) @(posedge clk_sys);
		check("queue", exp_q.size(), 32'h0);
		close_out();
	end
endmodule // test_burst_wrap_read_latency_config

`default_nettype wire
